// ===== shared/psa_pkg.sv
`default_nettype none
// ****************************************
// widths, lane limits and encodings
// ****************************************
package psa_pkg;
  localparam int PSA_DATA_W      = 64;  // one vector register
  localparam int PSA_GPR_W       = 32;  // general-purpose register
  localparam int PSA_NREG        = 8;   // vector registers
  localparam int PSA_IDX_W       = 3;
  localparam int PSA_JUST_W      = 32;  // lane engine works on left-justified lanes
  localparam int PSA_BYTE_W      = 8;
  localparam int PSA_WORD_W      = 16;
  localparam int PSA_DWORD_W     = 32;
  localparam int PSA_NLANE_MAX   = 8;
  localparam int PSA_FEATURE_BIT = 23;  // presence bit in the feature word

  // clamps for a left-justified lane; the top lane bits give 7F/80, 7FFF/8000, FF/00
  localparam logic [31:0] PSA_JUST_SMAX = 32'h7FFF_FFFF;
  localparam logic [31:0] PSA_JUST_SMIN = 32'h8000_0000;
  localparam logic [31:0] PSA_JUST_UMAX = 32'hFFFF_FFFF;
  localparam logic [31:0] PSA_JUST_UMIN = 32'h0000_0000;

  // clamps used by the narrowing operations
  localparam logic [7:0]  PSA_SBYTE_MAX = 8'h7F;
  localparam logic [7:0]  PSA_SBYTE_MIN = 8'h80;
  localparam logic [7:0]  PSA_UBYTE_MAX = 8'hFF;
  localparam logic [7:0]  PSA_UBYTE_MIN = 8'h00;
  localparam logic [15:0] PSA_SWORD_MAX = 16'h7FFF;
  localparam logic [15:0] PSA_SWORD_MIN = 16'h8000;

  localparam logic [63:0] PSA_VREG_RESET = 64'h0000_0000_0000_0000;

  typedef enum logic [4:0] {
    PSA_OP_MOV32_LOAD     = 5'h00,
    PSA_OP_MOV32_STORE    = 5'h01,
    PSA_OP_MOV32_FROM_GPR = 5'h02,
    PSA_OP_MOV32_TO_GPR   = 5'h03,
    PSA_OP_MOV64_LOAD     = 5'h04,
    PSA_OP_MOV64_STORE    = 5'h05,
    PSA_OP_MOV64_REG      = 5'h06,
    PSA_OP_ADD_WRAP       = 5'h07,
    PSA_OP_SUB_WRAP       = 5'h08,
    PSA_OP_ADD_SSAT       = 5'h09,
    PSA_OP_SUB_SSAT       = 5'h0A,
    PSA_OP_ADD_USAT       = 5'h0B,
    PSA_OP_SUB_USAT       = 5'h0C,
    PSA_OP_MUL_HIGH       = 5'h0D,
    PSA_OP_MUL_LOW        = 5'h0E,
    PSA_OP_MUL_SUM        = 5'h0F,
    PSA_OP_CMP_EQ         = 5'h10,
    PSA_OP_CMP_GT         = 5'h11,
    PSA_OP_NARROW_W_SB    = 5'h12,
    PSA_OP_NARROW_D_SW    = 5'h13,
    PSA_OP_NARROW_W_UB    = 5'h14,
    PSA_OP_UNPACK         = 5'h15,
    PSA_OP_LOGIC          = 5'h16,
    PSA_OP_SHIFT          = 5'h17,
    PSA_OP_EMPTY_STATE    = 5'h18
  } psa_op_type;

  typedef enum logic [1:0] {
    PSA_LANE_BYTE  = 2'h0,
    PSA_LANE_WORD  = 2'h1,
    PSA_LANE_DWORD = 2'h2,
    PSA_LANE_QUAD  = 2'h3
  } psa_lane_type;

  typedef enum logic [1:0] {
    PSA_SAT_WRAP     = 2'h0,
    PSA_SAT_SIGNED   = 2'h1,
    PSA_SAT_UNSIGNED = 2'h2
  } psa_sat_type;
endpackage
`default_nettype wire

// ===== src/psa_lane_arith.sv
`timescale 1ns/1ps
`default_nettype none
// packed add, subtract and compare over byte, word or dword lanes
module psa_lane_arith import psa_pkg::*; (
  input  wire logic [63:0] i_a,
  input  wire logic [63:0] i_b,
  input  wire logic        i_sub,
  input  wire psa_sat_type i_sat,
  input  wire psa_lane_type i_lane,
  output logic      [63:0] o_sum,
  output logic      [63:0] o_eq,
  output logic      [63:0] o_gt
);

  // lane width in bits; quad reaches here only on ops that ignore the result, it maps to dword harmlessly
  function automatic int lane_bits(input psa_lane_type l);
    unique case (l)
      PSA_LANE_BYTE: return PSA_BYTE_W;
      PSA_LANE_WORD: return PSA_WORD_W;
      default:       return PSA_DWORD_W;
    endcase
  endfunction

  // one lane, justified to bit 31 so a single adder serves all widths
  function automatic logic [31:0] just_op(input logic [31:0] a, input logic [31:0] b,
                                          input logic sub, input psa_sat_type m);
    logic [32:0] ea;
    logic [32:0] eb;
    logic [32:0] s;
    logic [31:0] r;
    ea = (m == PSA_SAT_SIGNED) ? {a[31], a} : {1'b0, a};
    eb = (m == PSA_SAT_SIGNED) ? {b[31], b} : {1'b0, b};
    s  = sub ? (ea - eb) : (ea + eb);
    r  = s[31:0];                                      // carries dropped
    if (m == PSA_SAT_SIGNED && s[32] != s[31]) begin
      r = s[32] ? PSA_JUST_SMIN : PSA_JUST_SMAX;
    end else if (m == PSA_SAT_UNSIGNED && s[32]) begin
      r = sub ? PSA_JUST_UMIN : PSA_JUST_UMAX;
    end
    return r;
  endfunction

  // lane loop; lane 0 sits in the low bits
  always_comb begin
    int          w;
    int          n;
    logic [63:0] ta;
    logic [63:0] tb;
    logic [31:0] ja;
    logic [31:0] jb;
    logic [31:0] r;
    logic [63:0] m;
    w = lane_bits(i_lane);
    n = PSA_DATA_W / w;
    ta = '0;
    tb = '0;
    ja = '0;
    jb = '0;
    r = '0;
    m = '0;
    o_sum = '0;
    o_eq = '0;
    o_gt = '0;
    for (int i = 0; i < PSA_NLANE_MAX; i++) begin
      if (i < n) begin
        ta = i_a >> (i * w);
        tb = i_b >> (i * w);
        ja = ta[PSA_JUST_W-1:0] << (PSA_JUST_W - w);
        jb = tb[PSA_JUST_W-1:0] << (PSA_JUST_W - w);
        r = just_op(ja, jb, i_sub, i_sat);
        m = ({PSA_DATA_W{1'b1}} >> (PSA_DATA_W - w)) << (i * w);
        o_sum = o_sum | (PSA_DATA_W'(r >> (PSA_JUST_W - w)) << (i * w));
        if (ja == jb) begin
          o_eq = o_eq | m;
        end
        if ($signed(ja) > $signed(jb)) begin
          o_gt = o_gt | m;
        end
      end
    end
  end

endmodule // psa_lane_arith
`default_nettype wire

// ===== src/psa_mul_pack.sv
`timescale 1ns/1ps
`default_nettype none
// word multiplies and the three narrowing conversions
module psa_mul_pack import psa_pkg::*; (
  input  wire logic [63:0] i_a,
  input  wire logic [63:0] i_b,
  output logic      [63:0] o_mul_high,
  output logic      [63:0] o_mul_low,
  output logic      [63:0] o_mul_sum,
  output logic      [63:0] o_pack_sb,
  output logic      [63:0] o_pack_sw,
  output logic      [63:0] o_pack_ub
);

  // signed word to signed byte: in range when the top bits all copy the sign
  function automatic logic [7:0] sat_sb(input logic [15:0] v);
    if (v[PSA_WORD_W-1:PSA_BYTE_W-1] == {(PSA_WORD_W-PSA_BYTE_W+1){v[PSA_WORD_W-1]}})
      return v[PSA_BYTE_W-1:0];
    return v[PSA_WORD_W-1] ? PSA_SBYTE_MIN : PSA_SBYTE_MAX;
  endfunction

  function automatic logic [15:0] sat_sw(input logic [31:0] v);
    if (v[PSA_DWORD_W-1:PSA_WORD_W-1] == {(PSA_DWORD_W-PSA_WORD_W+1){v[PSA_DWORD_W-1]}})
      return v[PSA_WORD_W-1:0];
    return v[PSA_DWORD_W-1] ? PSA_SWORD_MIN : PSA_SWORD_MAX;
  endfunction

  // negative goes to zero, above the byte range goes to all ones
  function automatic logic [7:0] sat_ub(input logic [15:0] v);
    if (v[PSA_WORD_W-1])
      return PSA_UBYTE_MIN;
    if (|v[PSA_WORD_W-2:PSA_BYTE_W])
      return PSA_UBYTE_MAX;
    return v[PSA_BYTE_W-1:0];
  endfunction

  // four signed products, each kept whole at 32 bits
  always_comb begin
    logic signed [31:0] p [4];
    for (int i = 0; i < 4; i++) begin
      p[i] = '0;
    end
    o_mul_high = '0;
    o_mul_low  = '0;
    for (int i = 0; i < 4; i++) begin
      p[i] = $signed(i_a[i*PSA_WORD_W +: PSA_WORD_W]) * $signed(i_b[i*PSA_WORD_W +: PSA_WORD_W]);
      o_mul_high[i*PSA_WORD_W +: PSA_WORD_W] = p[i][PSA_DWORD_W-1:PSA_WORD_W];
      o_mul_low[i*PSA_WORD_W +: PSA_WORD_W]  = p[i][PSA_WORD_W-1:0];
    end
    o_mul_sum = {32'(p[3] + p[2]), 32'(p[1] + p[0])};
  end

  // destination elements fill the low half, source elements the high half
  always_comb begin
    o_pack_sb = '0;
    o_pack_sw = '0;
    o_pack_ub = '0;
    for (int i = 0; i < 4; i++) begin
      o_pack_sb[i*PSA_BYTE_W +: PSA_BYTE_W]     = sat_sb(i_a[i*PSA_WORD_W +: PSA_WORD_W]);
      o_pack_sb[(i+4)*PSA_BYTE_W +: PSA_BYTE_W] = sat_sb(i_b[i*PSA_WORD_W +: PSA_WORD_W]);
      o_pack_ub[i*PSA_BYTE_W +: PSA_BYTE_W]     = sat_ub(i_a[i*PSA_WORD_W +: PSA_WORD_W]);
      o_pack_ub[(i+4)*PSA_BYTE_W +: PSA_BYTE_W] = sat_ub(i_b[i*PSA_WORD_W +: PSA_WORD_W]);
    end
    for (int i = 0; i < 2; i++) begin
      o_pack_sw[i*PSA_WORD_W +: PSA_WORD_W]     = sat_sw(i_a[i*PSA_DWORD_W +: PSA_DWORD_W]);
      o_pack_sw[(i+2)*PSA_WORD_W +: PSA_WORD_W] = sat_sw(i_b[i*PSA_DWORD_W +: PSA_DWORD_W]);
    end
  end

endmodule // psa_mul_pack
`default_nettype wire

// ===== src/psa_alu.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - 32-bit move: memory or GPR with vector register
// - 64-bit move: memory or vector register copy
// - wraparound add/sub per lane, carries dropped
// - signed saturating byte/word add and subtract
// - unsigned saturating byte/word add and subtract
// - signed word multiply, keep high or low half
// - multiply words, sum product pairs into dwords
// - compare lanes for equality
// - signed greater-than compare, destination versus source
// - compare writes all-ones or all-zeros lane masks
// - compares never touch the flags register
// - signed narrowing clamps to narrower signed range
// - unsigned narrowing clamps words to zero..FF
// - group works only when feature bit 23 set
// - decoder recognises the whole instruction group
// - signed clamps 7FFF/8000 and 7F/80
// - unsigned clamps all-ones or zero
// - overflow raises nothing and sets no flag
// - eight 64-bit vector registers hold operands
module psa_alu import psa_pkg::*; (
  input  wire logic          i_clk,
  input  wire logic          i_rst,
  input  wire logic          i_feature_en,
  input  wire logic          i_valid,
  input  wire psa_op_type    i_op,
  input  wire psa_lane_type  i_lane,
  input  wire logic [2:0]    i_dst_idx,
  input  wire logic [2:0]    i_src_idx,
  input  wire logic          i_src_mem,
  input  wire logic [63:0]   i_mem_rdata,
  input  wire logic [31:0]   i_gpr_rdata,
  output logic               o_done,
  output logic               o_illegal,
  output logic               o_deferred,
  output logic               o_vreg_we,
  output logic [2:0]         o_vreg_idx,
  output logic [63:0]        o_result,
  output logic               o_mem_we,
  output logic               o_mem_wide,
  output logic [63:0]        o_mem_wdata,
  output logic               o_gpr_we,
  output logic [31:0]        o_gpr_wdata,
  output logic               o_flags_we,
  output logic [31:0]        o_feature_word
);

  // ****************************************
  // state and operands
  // ****************************************
  logic [63:0] vreg_reg [PSA_NREG];
  logic [63:0] vreg_next [PSA_NREG];
  logic        feature_reg;
  logic        done_reg, done_next;
  logic        illegal_reg, illegal_next;
  logic        deferred_reg, deferred_next;
  logic        vreg_we_reg, vreg_we_next;
  logic [2:0]  vreg_idx_reg, vreg_idx_next;
  logic [63:0] result_reg, result_next;
  logic        mem_we_reg, mem_we_next;
  logic        mem_wide_reg, mem_wide_next;
  logic [63:0] mem_wdata_reg, mem_wdata_next;
  logic        gpr_we_reg, gpr_we_next;
  logic [31:0] gpr_wdata_reg, gpr_wdata_next;
  logic [63:0] opa;
  logic [63:0] vsrc;
  logic [63:0] opb;
  logic        accept;
  logic        arith_sub;
  psa_sat_type arith_sat;
  logic [63:0] arith_sum, cmp_eq, cmp_gt;
  logic [63:0] mul_high, mul_low, mul_sum;
  logic [63:0] pack_sb, pack_sw, pack_ub;

  // lane size must suit the operation; reserved codes are refused
  function automatic logic op_legal(input psa_op_type op, input psa_lane_type l);
    unique case (op)
      PSA_OP_ADD_WRAP, PSA_OP_SUB_WRAP, PSA_OP_CMP_EQ, PSA_OP_CMP_GT:
        return l != PSA_LANE_QUAD;
      PSA_OP_ADD_SSAT, PSA_OP_SUB_SSAT, PSA_OP_ADD_USAT, PSA_OP_SUB_USAT:
        return l == PSA_LANE_BYTE || l == PSA_LANE_WORD;
      PSA_OP_MOV32_LOAD, PSA_OP_MOV32_STORE, PSA_OP_MOV32_FROM_GPR, PSA_OP_MOV32_TO_GPR,
      PSA_OP_MOV64_LOAD, PSA_OP_MOV64_STORE, PSA_OP_MOV64_REG, PSA_OP_MUL_HIGH,
      PSA_OP_MUL_LOW, PSA_OP_MUL_SUM, PSA_OP_NARROW_W_SB, PSA_OP_NARROW_D_SW,
      PSA_OP_NARROW_W_UB, PSA_OP_UNPACK, PSA_OP_LOGIC, PSA_OP_SHIFT, PSA_OP_EMPTY_STATE:
        return 1'b1;
      default:
        return 1'b0;
    endcase
  endfunction

  // destination is also the first operand; source may come from memory
  assign opa  = vreg_reg[i_dst_idx];
  assign vsrc = vreg_reg[i_src_idx];
  assign opb  = i_src_mem ? i_mem_rdata : vsrc;
  assign accept = i_valid && feature_reg && op_legal(i_op, i_lane);

  // subtract variants and saturation mode for the lane engine
  assign arith_sub = (i_op == PSA_OP_SUB_WRAP) || (i_op == PSA_OP_SUB_SSAT) ||
                     (i_op == PSA_OP_SUB_USAT);
  assign arith_sat = (i_op == PSA_OP_ADD_SSAT || i_op == PSA_OP_SUB_SSAT) ? PSA_SAT_SIGNED :
                     (i_op == PSA_OP_ADD_USAT || i_op == PSA_OP_SUB_USAT) ? PSA_SAT_UNSIGNED :
                     PSA_SAT_WRAP;

  psa_lane_arith u_lane_arith (
    .i_a    (opa),
    .i_b    (opb),
    .i_sub  (arith_sub),
    .i_sat  (arith_sat),
    .i_lane (i_lane),
    .o_sum  (arith_sum),
    .o_eq   (cmp_eq),
    .o_gt   (cmp_gt)
  );

  psa_mul_pack u_mul_pack (
    .i_a        (opa),
    .i_b        (opb),
    .o_mul_high (mul_high),
    .o_mul_low  (mul_low),
    .o_mul_sum  (mul_sum),
    .o_pack_sb  (pack_sb),
    .o_pack_sw  (pack_sw),
    .o_pack_ub  (pack_ub)
  );

  // ****************************************
  // execute: one request, one answer a cycle later
  // ****************************************
  always_comb begin
    done_next      = 1'b0;
    illegal_next   = 1'b0;
    deferred_next  = 1'b0;
    vreg_we_next   = 1'b0;
    mem_we_next    = 1'b0;
    gpr_we_next    = 1'b0;
    vreg_idx_next  = vreg_idx_reg;
    result_next    = result_reg;
    mem_wide_next  = mem_wide_reg;
    mem_wdata_next = mem_wdata_reg;
    gpr_wdata_next = gpr_wdata_reg;
    for (int i = 0; i < PSA_NREG; i++) begin
      vreg_next[i] = vreg_reg[i];
    end
    if (i_valid && !accept) begin
      illegal_next = 1'b1;
    end else if (accept) begin
      done_next     = 1'b1;
      vreg_we_next  = 1'b1;
      vreg_idx_next = i_dst_idx;
      unique case (i_op)
        PSA_OP_MOV32_LOAD:     result_next = PSA_DATA_W'(i_mem_rdata[PSA_GPR_W-1:0]);
        PSA_OP_MOV32_FROM_GPR: result_next = PSA_DATA_W'(i_gpr_rdata);
        PSA_OP_MOV32_STORE: begin
          vreg_we_next   = 1'b0;
          mem_we_next    = 1'b1;
          mem_wide_next  = 1'b0;
          mem_wdata_next = PSA_DATA_W'(vsrc[PSA_GPR_W-1:0]);
        end
        PSA_OP_MOV32_TO_GPR: begin
          vreg_we_next   = 1'b0;
          gpr_we_next    = 1'b1;
          gpr_wdata_next = vsrc[PSA_GPR_W-1:0];
        end
        PSA_OP_MOV64_LOAD:     result_next = i_mem_rdata;
        PSA_OP_MOV64_REG:      result_next = vsrc;
        PSA_OP_MOV64_STORE: begin
          vreg_we_next   = 1'b0;
          mem_we_next    = 1'b1;
          mem_wide_next  = 1'b1;
          mem_wdata_next = vsrc;
        end
        PSA_OP_ADD_WRAP, PSA_OP_SUB_WRAP, PSA_OP_ADD_SSAT, PSA_OP_SUB_SSAT,
        PSA_OP_ADD_USAT, PSA_OP_SUB_USAT:
          result_next = arith_sum;
        PSA_OP_MUL_HIGH:       result_next = mul_high;
        PSA_OP_MUL_LOW:        result_next = mul_low;
        PSA_OP_MUL_SUM:        result_next = mul_sum;
        PSA_OP_CMP_EQ:         result_next = cmp_eq;
        PSA_OP_CMP_GT:         result_next = cmp_gt;
        PSA_OP_NARROW_W_SB:    result_next = pack_sb;
        PSA_OP_NARROW_D_SW:    result_next = pack_sw;
        PSA_OP_NARROW_W_UB:    result_next = pack_ub;
        default: begin
          // recognised group members executed by a neighbouring unit
          done_next     = 1'b0;
          vreg_we_next  = 1'b0;
          deferred_next = 1'b1;
        end
      endcase
      if (vreg_we_next) begin
        vreg_next[i_dst_idx] = result_next;
      end
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < PSA_NREG; i++) begin
        vreg_reg[i] <= PSA_VREG_RESET;
      end
      feature_reg   <= 1'b0;
      done_reg      <= 1'b0;
      illegal_reg   <= 1'b0;
      deferred_reg  <= 1'b0;
      vreg_we_reg   <= 1'b0;
      vreg_idx_reg  <= '0;
      result_reg    <= '0;
      mem_we_reg    <= 1'b0;
      mem_wide_reg  <= 1'b0;
      mem_wdata_reg <= '0;
      gpr_we_reg    <= 1'b0;
      gpr_wdata_reg <= '0;
    end else begin
      vreg_reg      <= vreg_next;
      feature_reg   <= i_feature_en;                    // strap sampled on every clock after release
      done_reg      <= done_next;
      illegal_reg   <= illegal_next;
      deferred_reg  <= deferred_next;
      vreg_we_reg   <= vreg_we_next;
      vreg_idx_reg  <= vreg_idx_next;
      result_reg    <= result_next;
      mem_we_reg    <= mem_we_next;
      mem_wide_reg  <= mem_wide_next;
      mem_wdata_reg <= mem_wdata_next;
      gpr_we_reg    <= gpr_we_next;
      gpr_wdata_reg <= gpr_wdata_next;
    end
  end

  // outputs; overflow and compares have no path to the flags at all
  assign o_done         = done_reg;
  assign o_illegal      = illegal_reg;
  assign o_deferred     = deferred_reg;
  assign o_vreg_we      = vreg_we_reg;
  assign o_vreg_idx     = vreg_idx_reg;
  assign o_result       = result_reg;
  assign o_mem_we       = mem_we_reg;
  assign o_mem_wide     = mem_wide_reg;
  assign o_mem_wdata    = mem_wdata_reg;
  assign o_gpr_we       = gpr_we_reg;
  assign o_gpr_wdata    = gpr_wdata_reg;
  assign o_flags_we     = 1'b0;
  assign o_feature_word = PSA_GPR_W'(feature_reg) << PSA_FEATURE_BIT;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  logic [15:0]        chk_wsum;
  logic signed [31:0] chk_prod0;
  logic signed [31:0] chk_prod1;
  logic [31:0]        chk_madd;
  assign chk_wsum  = 16'(opa[15:0] + opb[15:0]);
  // products land in 32-bit nets so the word operands are sign-extended first
  assign chk_prod0 = $signed(opa[15:0]) * $signed(opb[15:0]);
  assign chk_prod1 = $signed(opa[31:16]) * $signed(opb[31:16]);
  assign chk_madd  = 32'(chk_prod0 + chk_prod1);

  property p_wrap_byte;
    accept && i_op == PSA_OP_ADD_WRAP && i_lane == PSA_LANE_BYTE
      |=> o_done && o_result[7:0] == 8'($past(opa) + $past(opb));
  endproperty
  a_wrap_byte: assert property (p_wrap_byte) else $error("byte wrap add wrong");

  property p_ssat_word;
    accept && i_op == PSA_OP_ADD_SSAT && i_lane == PSA_LANE_WORD &&
      !opa[15] && !opb[15] && chk_wsum[15] |=> o_result[15:0] == PSA_SWORD_MAX;
  endproperty
  a_ssat_word: assert property (p_ssat_word) else $error("word clamp missed");

  property p_usat_byte;
    accept && i_op == PSA_OP_SUB_USAT && i_lane == PSA_LANE_BYTE && opa[7:0] < opb[7:0]
      |=> o_result[7:0] == PSA_UBYTE_MIN;
  endproperty
  a_usat_byte: assert property (p_usat_byte) else $error("unsigned floor missed");

  property p_mul_low;
    accept && i_op == PSA_OP_MUL_LOW |=> o_result[15:0] == 16'($past(opa) * $past(opb));
  endproperty
  a_mul_low: assert property (p_mul_low) else $error("low product wrong");

  property p_mul_sum;
    accept && i_op == PSA_OP_MUL_SUM |=> o_result[31:0] == $past(chk_madd);
  endproperty
  a_mul_sum: assert property (p_mul_sum) else $error("pair sum wrong");

  property p_cmp_eq;
    accept && i_op == PSA_OP_CMP_EQ && i_lane == PSA_LANE_DWORD && opa[63:32] == opb[63:32]
      |=> o_result[63:32] == '1 && o_vreg_we;
  endproperty
  a_cmp_eq: assert property (p_cmp_eq) else $error("equal mask wrong");

  property p_cmp_gt;
    accept && i_op == PSA_OP_CMP_GT && i_lane == PSA_LANE_BYTE &&
      $signed(opa[7:0]) <= $signed(opb[7:0]) |=> o_result[7:0] == '0;
  endproperty
  a_cmp_gt: assert property (p_cmp_gt) else $error("greater mask wrong");

  property p_narrow_ub;
    accept && i_op == PSA_OP_NARROW_W_UB && opa[15] |=> o_result[7:0] == PSA_UBYTE_MIN;
  endproperty
  a_narrow_ub: assert property (p_narrow_ub) else $error("negative not zeroed");

  property p_feature_off;
    i_valid && !feature_reg |=> o_illegal && !o_done && !o_vreg_we ##1 !o_illegal || $past(i_valid);
  endproperty
  a_feature_off: assert property (p_feature_off) else $error("ran without feature");

  property p_to_gpr;
    accept && i_op == PSA_OP_MOV32_TO_GPR
      |=> o_gpr_we && !o_vreg_we && o_gpr_wdata == 32'($past(vsrc));
  endproperty
  a_to_gpr: assert property (p_to_gpr) else $error("gpr move wrong");

  property p_store64;
    accept && i_op == PSA_OP_MOV64_STORE |=> o_mem_we && o_mem_wide && o_mem_wdata == $past(vsrc);
  endproperty
  a_store64: assert property (p_store64) else $error("quad store wrong");

  property p_vreg_hold;
    o_vreg_we |-> vreg_reg[o_vreg_idx] == o_result;
  endproperty
  a_vreg_hold: assert property (p_vreg_hold) else $error("register file lost write");

endmodule // psa_alu
`default_nettype wire

// ===== testbench/psa_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// memory side of the core: one 64-bit word
// ****************************************
module psa_core_model (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_fill,
  input  wire logic [63:0] i_fill_data,
  input  wire logic        i_mem_we,
  input  wire logic [63:0] i_mem_wdata,
  output logic      [63:0] o_mem_rdata
);
  // a store wins over a bench fill so stored data is never lost
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) o_mem_rdata <= 64'h0;
    else if (i_mem_we) o_mem_rdata <= i_mem_wdata;
    else if (i_fill) o_mem_rdata <= i_fill_data;
  end
endmodule // psa_core_model
`default_nettype wire

// ===== testbench/packed_simd_integer_alu_bench.sv
`timescale 1ns/1ps
`default_nettype none
module packed_simd_integer_alu_bench import psa_pkg::*; ;
  localparam logic [63:0] A1 = 64'h807FFF01_807FFF01;
  localparam logic [63:0] B1 = 64'h01010101_01010101;
  localparam logic [63:0] A2 = 64'h80007FFF_FFFF0003;
  localparam logic [63:0] B2 = 64'h00020002_00020002;
  localparam logic [63:0] A3 = 64'h8000FFFF_00037FFF;
  localparam logic [63:0] B3 = 64'h80000002_00020002;
  logic         i_clk, i_rst, i_feature_en, i_valid, i_src_mem, i_fill;
  psa_op_type   i_op;
  psa_lane_type i_lane;
  logic [2:0]   i_dst_idx, i_src_idx, o_vreg_idx;
  logic [63:0]  i_mem_rdata, i_fill_data, o_result, o_mem_wdata;
  logic [31:0]  i_gpr_rdata, o_gpr_wdata, o_feature_word;
  logic         o_done, o_illegal, o_deferred, o_vreg_we;
  logic         o_mem_we, o_mem_wide, o_gpr_we, o_flags_we;
  int           err_total, n_compared, cyc;

  psa_alu dut (.i_clk, .i_rst, .i_feature_en, .i_valid, .i_op, .i_lane, .i_dst_idx,
    .i_src_idx, .i_src_mem, .i_mem_rdata, .i_gpr_rdata, .o_done, .o_illegal, .o_deferred,
    .o_vreg_we, .o_vreg_idx, .o_result, .o_mem_we, .o_mem_wide, .o_mem_wdata, .o_gpr_we,
    .o_gpr_wdata, .o_flags_we, .o_feature_word);
  psa_core_model mem (.i_clk, .i_rst, .i_fill, .i_fill_data, .i_mem_we(o_mem_we),
    .i_mem_wdata(o_mem_wdata), .o_mem_rdata(i_mem_rdata));

  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  // hang guard: the whole run needs about 134 cycles
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 1000) begin
      err_total++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("mismatches %0d, compared %0d", err_total, n_compared);
    if (err_total == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // one request, answer sampled just after the edge that takes it
  task automatic issue(psa_op_type op, psa_lane_type ln, logic [2:0] d, logic [2:0] s, logic m);
    @(posedge i_clk);
    #1 {i_valid, i_dst_idx, i_src_idx, i_src_mem} = {1'b1, d, s, m};
    i_op = op;
    i_lane = ln;
    @(posedge i_clk);
    #1 i_valid = 1'b0;
  endtask
  task automatic fill(input logic [63:0] v);
    {i_fill, i_fill_data} = {1'b1, v};
    @(posedge i_clk);
    #1 i_fill = 1'b0;
  endtask
  // operand a goes to vector register 1, b comes straight from memory
  task automatic run(psa_op_type op, psa_lane_type ln, logic [63:0] a, b, e);
    fill(a);
    issue(PSA_OP_MOV64_LOAD, PSA_LANE_QUAD, 3'h1, 3'h0, 1'b1);
    fill(b);
    issue(op, ln, 3'h1, 3'h0, 1'b1);
    chk({o_done, o_vreg_we, o_vreg_idx, o_flags_we}, 6'b110010);
    chk(o_result, e);
  endtask

  task automatic t_moves();
    fill(64'hFFFFFFFF_89ABCDEF);
    issue(PSA_OP_MOV64_LOAD, PSA_LANE_QUAD, 3'h2, 3'h0, 1'b1);
    issue(PSA_OP_MOV64_REG, PSA_LANE_QUAD, 3'h4, 3'h2, 1'b0);
    chk(o_result, 64'hFFFFFFFF_89ABCDEF);
    issue(PSA_OP_MOV64_STORE, PSA_LANE_QUAD, 3'h0, 3'h4, 1'b0);
    chk({o_mem_we, o_mem_wide, o_mem_wdata[63:62]}, 4'hF);
    issue(PSA_OP_MOV32_LOAD, PSA_LANE_DWORD, 3'h5, 3'h0, 1'b1);
    chk(o_result, 64'h00000000_89ABCDEF);
    issue(PSA_OP_MOV32_STORE, PSA_LANE_DWORD, 3'h0, 3'h2, 1'b0);
    chk({o_mem_we, o_mem_wide}, 2'h2);
    chk(o_mem_wdata, 64'h00000000_89ABCDEF);
    i_gpr_rdata = 32'h13572468;
    issue(PSA_OP_MOV32_FROM_GPR, PSA_LANE_DWORD, 3'h6, 3'h0, 1'b0);
    issue(PSA_OP_MOV32_TO_GPR, PSA_LANE_DWORD, 3'h0, 3'h6, 1'b0);
    chk({o_gpr_we, o_gpr_wdata}, 33'h113572468);
  endtask
  task automatic t_arith();
    run(PSA_OP_ADD_WRAP, PSA_LANE_BYTE, A1, B1, 64'h81800002_81800002);
    run(PSA_OP_ADD_SSAT, PSA_LANE_BYTE, A1, B1, 64'h817F0002_817F0002);
    run(PSA_OP_SUB_SSAT, PSA_LANE_BYTE, A1, B1, 64'h807EFE00_807EFE00);
    run(PSA_OP_ADD_USAT, PSA_LANE_BYTE, A1, B1, 64'h8180FF02_8180FF02);
    run(PSA_OP_SUB_USAT, PSA_LANE_BYTE, A1, B1, 64'h7F7EFE00_7F7EFE00);
    run(PSA_OP_ADD_SSAT, PSA_LANE_WORD, A3, B3, 64'h80000001_00057FFF);
    run(PSA_OP_ADD_USAT, PSA_LANE_WORD, A2, B2, 64'h80028001_FFFF0005);
    run(PSA_OP_SUB_WRAP, PSA_LANE_DWORD, A2, B2, 64'h7FFE7FFD_FFFD0001);
    run(PSA_OP_CMP_GT, PSA_LANE_WORD, A2, B2, 64'h0000FFFF_0000FFFF);
    run(PSA_OP_CMP_EQ, PSA_LANE_DWORD, A1, {A1[63:32], 32'h0}, 64'hFFFFFFFF_00000000);
    run(PSA_OP_CMP_EQ, PSA_LANE_BYTE, A1, B1, 64'h000000FF_000000FF);
    run(PSA_OP_CMP_GT, PSA_LANE_BYTE, A1, B1, 64'h00FF0000_00FF0000);
    run(PSA_OP_MUL_HIGH, PSA_LANE_WORD, A2, B2, 64'hFFFF0000_FFFF0000);
    run(PSA_OP_MUL_LOW, PSA_LANE_WORD, A2, B2, 64'h0000FFFE_FFFE0006);
    run(PSA_OP_MUL_SUM, PSA_LANE_WORD, A2, B2, 64'hFFFFFFFE_00000004);
    run(PSA_OP_NARROW_W_SB, PSA_LANE_WORD, A2, B2, 64'h02020202_807FFF03);
    run(PSA_OP_NARROW_D_SW, PSA_LANE_DWORD, A2, B2, 64'h7FFF7FFF_80008000);
    run(PSA_OP_NARROW_W_UB, PSA_LANE_WORD, A2, B2, 64'h02020202_00FF0003);
  endtask
  task automatic t_refuse();
    issue(PSA_OP_ADD_WRAP, PSA_LANE_QUAD, 3'h1, 3'h0, 1'b1);
    chk({o_done, o_illegal, o_deferred, o_vreg_we}, 4'b0100);
    issue(PSA_OP_SHIFT, PSA_LANE_WORD, 3'h1, 3'h0, 1'b1);
    chk({o_done, o_illegal, o_deferred, o_vreg_we}, 4'b0010);
    issue(psa_op_type'(5'h1F), PSA_LANE_BYTE, 3'h1, 3'h0, 1'b1);
    chk({o_done, o_illegal, o_deferred, o_vreg_we}, 4'h4);
    chk(o_feature_word, 64'h00800000);
    i_feature_en = 1'b0;
    issue(PSA_OP_MOV64_REG, PSA_LANE_QUAD, 3'h1, 3'h2, 1'b0);
    chk({o_done, o_illegal, o_vreg_we, o_feature_word}, 35'h200000000);
  endtask

  initial begin
    {i_rst, i_feature_en, i_valid, i_src_mem, i_fill} = 5'b11000;
    {i_dst_idx, i_src_idx, i_gpr_rdata, i_fill_data} = '0;
    i_op = PSA_OP_MOV64_LOAD;
    i_lane = PSA_LANE_QUAD;
    repeat (3) @(posedge i_clk);
    #1 i_rst = 1'b0;
    t_moves();
    t_arith();
    t_refuse();
    give_verdict();
  end
endmodule // packed_simd_integer_alu_bench
`default_nettype wire
